// ---- doorbell_mailbox.sv ----
// doorbell and mailbox message passing between host and local ports
`timescale 1ns/10ps
`default_nettype none
`include "doorbell_defs.svh"
module doorbell_mailbox
    import doorbell_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic pci_sel_in,
    input wire logic pci_wr_in,
    input wire logic [3:0] pci_addr_in,
    input wire logic [31:0] pci_wdata_in,
    output logic [31:0] pci_rdata_out,
    output logic pci_ack_out,
    output logic pci_retry_out,
    output logic pci_irq_out,
    input wire logic loc_sel_in,
    input wire logic loc_wr_in,
    input wire logic [3:0] loc_addr_in,
    input wire logic [31:0] loc_wdata_in,
    output logic [31:0] loc_rdata_out,
    output logic loc_ack_out,
    output logic local_irq_line_out
);
    word_t message_box_r [8];
    word_t message_box_nxt [8];
    word_t ctl_r;
    word_t ctl_nxt;
    word_t host_to_local_bell;
    word_t local_to_host_bell;
    word_t h2l_nxt;
    word_t l2h_nxt;
    word_t h2l_set;
    word_t h2l_clr;
    word_t l2h_set;
    word_t l2h_clr;
    word_t pci_rdata_nxt;
    word_t loc_rdata_nxt;
    logic pci_ack_nxt;
    logic pci_retry_nxt;
    logic pci_irq_nxt;
    logic loc_ack_nxt;
    logic loc_irq_nxt;
    target_e pci_t;
    target_e loc_t;
    logic pci_clash;
    logic pci_go;
    logic pw;
    logic lw;
    logic mbox_irq_hit;

    function automatic target_e decode(input logic [3:0] a);
        if (a <= `REG_MBOX_LAST)
            return T_MBOX;
        else if (a == `REG_H2L_BELL)
            return T_H2L;
        else if (a == `REG_L2H_BELL)
            return T_L2H;
        else if (a == `REG_INT_CTL)
            return T_CTL;
        else
            return T_NONE;
    endfunction

    function automatic word_t read_reg(input logic [3:0] a);
        case (decode(a))
            T_MBOX: return message_box_r[a[2:0]];
            T_H2L: return host_to_local_bell;
            T_L2H: return local_to_host_bell;
            T_CTL: return ctl_r;
            default: return 32'h0000_0000;
        endcase
    endfunction

    always_comb
    begin
        pci_t = decode(pci_addr_in);
        loc_t = decode(loc_addr_in);
        pci_clash = pci_sel_in && loc_sel_in &&
            (loc_t == T_H2L || loc_t == T_L2H || loc_t == T_CTL);
        pci_go = pci_sel_in && !pci_clash;
        pw = pci_go && pci_wr_in;
        lw = loc_sel_in && loc_wr_in;
        mbox_irq_hit = pw && pci_t == T_MBOX &&
            pci_addr_in <= `REG_MBOX_IRQ_LAST &&
            ctl_r[`CTL_MBOX_EN] && ctl_r[`CTL_LOCAL_EN];
    end

    always_comb
    begin
        h2l_set = (pw && pci_t == T_H2L) ? pci_wdata_in : 32'h0;
        h2l_clr = (lw && loc_t == T_H2L) ? loc_wdata_in : 32'h0;
        l2h_set = (lw && loc_t == T_L2H) ? loc_wdata_in : 32'h0;
        l2h_clr = (pw && pci_t == T_L2H) ? pci_wdata_in : 32'h0;
    end

    doorbell_bits h2l_bell_inst (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(h2l_set),
        .clr_in(h2l_clr),
        .bits_out(host_to_local_bell),
        .bits_nxt_out(h2l_nxt)
    );

    doorbell_bits l2h_bell_inst (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(l2h_set),
        .clr_in(l2h_clr),
        .bits_out(local_to_host_bell),
        .bits_nxt_out(l2h_nxt)
    );

    // mailboxes: a host write in the same cycle lands over a local one
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            message_box_nxt[i] = message_box_r[i];
        if (lw && loc_t == T_MBOX)
            message_box_nxt[loc_addr_in[2:0]] = loc_wdata_in;
        if (pw && pci_t == T_MBOX)
            message_box_nxt[pci_addr_in[2:0]] = pci_wdata_in;
    end

    // control: two enables, plus a pending flag that the local side clears
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (lw && loc_t == T_CTL)
        begin
            ctl_nxt = (ctl_r & ~`CTL_WR_MASK) | (loc_wdata_in & `CTL_WR_MASK);
            if (loc_wdata_in[`CTL_MBOX_PEND])
                ctl_nxt[`CTL_MBOX_PEND] = 1'b0;
        end
        if (pw && pci_t == T_CTL)
            ctl_nxt = (ctl_nxt & ~`CTL_WR_MASK) | (pci_wdata_in & `CTL_WR_MASK);
        if (mbox_irq_hit)
            ctl_nxt[`CTL_MBOX_PEND] = 1'b1;
    end

    always_comb
    begin
        pci_ack_nxt = pci_go;
        pci_retry_nxt = pci_clash;
        pci_rdata_nxt = (pci_go && !pci_wr_in) ? read_reg(pci_addr_in) : 32'h0;
        loc_ack_nxt = loc_sel_in;
        loc_rdata_nxt = (loc_sel_in && !loc_wr_in) ?
            read_reg(loc_addr_in) : 32'h0;
        pci_irq_nxt = |l2h_nxt;
        loc_irq_nxt = (|h2l_nxt) || ctl_nxt[`CTL_MBOX_PEND];
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < 8; i++)
                message_box_r[i] <= `MBOX_RESET;
            ctl_r <= `CTL_RESET;
            pci_rdata_out <= 32'h0;
            pci_ack_out <= 1'b0;
            pci_retry_out <= 1'b0;
            pci_irq_out <= 1'b0;
            loc_rdata_out <= 32'h0;
            loc_ack_out <= 1'b0;
            local_irq_line_out <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
                message_box_r[i] <= message_box_nxt[i];
            ctl_r <= ctl_nxt;
            pci_rdata_out <= pci_rdata_nxt;
            pci_ack_out <= pci_ack_nxt;
            pci_retry_out <= pci_retry_nxt;
            pci_irq_out <= pci_irq_nxt;
            loc_rdata_out <= loc_rdata_nxt;
            loc_ack_out <= loc_ack_nxt;
            local_irq_line_out <= loc_irq_nxt;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_retry_on_clash: assert property (
        pci_sel_in && loc_sel_in && loc_addr_in == `REG_H2L_BELL
        |=> pci_retry_out && !pci_ack_out)
        else $error("host access not retried during local bell access");
    a_ack_when_free: assert property (
        pci_sel_in && !loc_sel_in |=> pci_ack_out && !pci_retry_out)
        else $error("free host access not acknowledged");
    a_local_ring_host: assert property (
        loc_sel_in && loc_wr_in && loc_addr_in == `REG_L2H_BELL &&
        loc_wdata_in != 32'h0 |=> pci_irq_out)
        else $error("local doorbell write did not raise host interrupt");
    a_host_ring_local: assert property (
        pw && pci_addr_in == `REG_H2L_BELL && pci_wdata_in != 32'h0
        |=> local_irq_line_out)
        else $error("host doorbell write did not raise local interrupt");
    a_host_irq_holds: assert property (
        pci_irq_out && !(pci_sel_in && pci_wr_in) |=> pci_irq_out)
        else $error("host interrupt dropped with no clearing write");
    a_local_only_sets: assert property (
        lw && loc_addr_in == `REG_L2H_BELL
        |=> (local_to_host_bell & $past(local_to_host_bell)) ==
            $past(local_to_host_bell))
        else $error("local write cleared a local-to-host bell bit");
    a_mbox_irq_raise: assert property (
        mbox_irq_hit ##1 !(loc_sel_in && loc_wr_in) |=> local_irq_line_out)
        else $error("mailbox write with both enables gave no interrupt");
    a_mbox_store: assert property (
        pw && pci_addr_in <= `REG_MBOX_LAST
        |=> message_box_r[$past(pci_addr_in[2:0])] == $past(pci_wdata_in))
        else $error("mailbox did not keep host write");
    a_high_mbox_quiet: assert property (
        pw && pci_addr_in > `REG_MBOX_IRQ_LAST &&
        pci_addr_in <= `REG_MBOX_LAST |=> !$rose(ctl_r[`CTL_MBOX_PEND]))
        else $error("upper mailbox write raised pending flag");
endmodule
`default_nettype wire

// ---- doorbell_defs.svh ----
// register indices, field positions and reset values of the messaging block
`ifndef DOORBELL_DEFS_SVH
`define DOORBELL_DEFS_SVH
`define REG_MBOX_LAST 4'h7
`define REG_MBOX_IRQ_LAST 4'h3
`define REG_H2L_BELL 4'h8
`define REG_L2H_BELL 4'h9
`define REG_INT_CTL 4'ha
`define CTL_MBOX_EN 3
`define CTL_LOCAL_EN 16
`define CTL_MBOX_PEND 27
`define CTL_WR_MASK 32'h0001_0008
`define BELL_RESET 32'h0000_0000
`define MBOX_RESET 32'h0000_0000
`define CTL_RESET 32'h0000_0000
`endif

// ---- doorbell_pkg.sv ----
// types shared by the messaging block
`default_nettype none
package doorbell_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [4:0] {
        T_NONE = 5'b00001,
        T_MBOX = 5'b00010,
        T_H2L = 5'b00100,
        T_L2H = 5'b01000,
        T_CTL = 5'b10000
    } target_e;
endpackage
`default_nettype wire

// ---- doorbell_bits.sv ----
// one doorbell register: one side sets bits, the other clears them
`timescale 1ns/10ps
`default_nettype none
`include "doorbell_defs.svh"
module doorbell_bits
    import doorbell_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire word_t set_in,
    input wire word_t clr_in,
    output word_t bits_out,
    output word_t bits_nxt_out
);
    word_t bits_r;
    word_t bits_nxt;

    // set wins over a clear in the same cycle
    always_comb
    begin
        bits_nxt = (bits_r & ~clr_in) | set_in;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            bits_r <= `BELL_RESET;
        else
            bits_r <= bits_nxt;
    end

    assign bits_out = bits_r;
    assign bits_nxt_out = bits_nxt;
endmodule
`default_nettype wire

// ---- local_cpu_model.sv ----
// behavioural local processor on the block's local port
`timescale 1ns/10ps
`default_nettype none
module local_cpu_model
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic go_in,
    input wire logic wr_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic done_out,
    output logic sel_out,
    output logic wr_out,
    output logic [3:0] addr_out,
    output logic [31:0] wdata_out,
    input wire logic [31:0] rdata_in,
    input wire logic ack_in
);
    // one access per go pulse, data inverted every cycle once released
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sel_out <= 1'b0;
            wr_out <= 1'b0;
            addr_out <= 4'h0;
            wdata_out <= 32'h0000_0000;
            rdata_out <= 32'h0000_0000;
            done_out <= 1'b0;
        end
        else
        begin
            sel_out <= go_in && !sel_out;
            if (go_in && !sel_out)
            begin
                wr_out <= wr_in;
                addr_out <= addr_in;
                wdata_out <= wdata_in;
            end
            else
                wdata_out <= ~wdata_out;
            done_out <= ack_in;
            if (ack_in)
                rdata_out <= rdata_in;
        end
    end
endmodule
`default_nettype wire

// ---- doorbell_mailbox_messaging_test.sv ----
// self-checking bench for the doorbell and mailbox block
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
        num_errors++; \
        $display("mismatch %s exp %h got %h", what, exp, got); \
    end
module doorbell_mailbox_messaging_test;
    import doorbell_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, go = 1'b0;
    logic gwr = 1'b0, ack, rty, pirq, lirq, lsel, lwr, lack, done, ak, rt;
    logic [3:0] adr = 4'h0, gadr = 4'h0, ladr;
    word_t wd = 32'h0, gwd = 32'h0, prd, lrd, lwd, mrd, rd;
    int num_errors = 0, tests_run = 0;
    doorbell_mailbox doorbell_mailbox_i (.sys_clk_in(clk), .reset_n_in(rst_n),
        .pci_sel_in(sel), .pci_wr_in(wr), .pci_addr_in(adr),
        .pci_wdata_in(wd), .pci_rdata_out(prd), .pci_ack_out(ack),
        .pci_retry_out(rty), .pci_irq_out(pirq), .loc_sel_in(lsel),
        .loc_wr_in(lwr), .loc_addr_in(ladr), .loc_wdata_in(lwd),
        .loc_rdata_out(lrd), .loc_ack_out(lack), .local_irq_line_out(lirq));
    local_cpu_model local_cpu_model_i (.clk_in(clk), .reset_n_in(rst_n),
        .go_in(go), .wr_in(gwr), .addr_in(gadr), .wdata_in(gwd),
        .rdata_out(mrd), .done_out(done), .sel_out(lsel), .wr_out(lwr),
        .addr_out(ladr), .wdata_out(lwd), .rdata_in(lrd), .ack_in(lack));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic host(input logic w, input logic [3:0] a, input word_t d);
        @(posedge clk);
        go <= 1'b0;
        sel <= 1'b1;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        sel <= 1'b0;
        wd <= ~d;
        @(posedge clk);
        rd = prd;
        ak = ack;
        rt = rty;
    endtask
    task automatic loc(input logic w, input logic [3:0] a, input word_t d);
        @(posedge clk);
        go <= 1'b1;
        gwr <= w;
        gadr <= a;
        gwd <= d;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 8 && !done; i++)
            @(posedge clk);
        `CHK("local ack", 1'b1, done)
    endtask
    task automatic t_bells();
        host(1'b1, 4'h8, 32'h0000_0005);
        `CHK("local irq set", 1'b1, lirq)
        host(1'b1, 4'h8, 32'h0000_0000);
        loc(1'b0, 4'h8, 32'h0);
        `CHK("h2l bell", 32'h0000_0005, mrd)
        loc(1'b1, 4'h8, 32'h0000_0001);
        host(1'b0, 4'h8, 32'h0);
        `CHK("h2l cleared bit", 32'h0000_0004, rd)
        `CHK("local irq held", 1'b1, lirq)
        loc(1'b1, 4'h8, 32'h0000_0004);
        `CHK("local irq drop", 1'b0, lirq)
        loc(1'b1, 4'h9, 32'h8000_0001);
        `CHK("host irq set", 1'b1, pirq)
        loc(1'b1, 4'h9, 32'h0);
        host(1'b1, 4'h9, 32'h0000_0001);
        host(1'b0, 4'h9, 32'h0);
        `CHK("l2h bell", 32'h8000_0000, rd)
        `CHK("host irq held", 1'b1, pirq)
        host(1'b1, 4'h9, 32'h8000_0000);
        `CHK("host irq drop", 1'b0, pirq)
    endtask
    task automatic t_mbox();
        for (int i = 0; i < 8; i++)
        begin
            host(1'b1, i[3:0], 32'h0a5a_0000 | i);
            loc(1'b0, i[3:0], 32'h0);
            `CHK("mbox local read", 32'h0a5a_0000 | i, mrd)
            loc(1'b1, i[3:0], ~(32'h0a5a_0000 | i));
            host(1'b0, i[3:0], 32'h0);
            `CHK("mbox host read", ~(32'h0a5a_0000 | i), rd)
        end
        `CHK("mbox no irq", 1'b0, lirq)
        host(1'b1, 4'ha, 32'h0001_0008);
        host(1'b1, 4'h5, 32'h1);
        `CHK("mbox5 no irq", 1'b0, lirq)
        host(1'b1, 4'h3, 32'h2);
        `CHK("message_box_three irq", 1'b1, lirq)
        loc(1'b1, 4'ha, 32'h0801_0008);
        `CHK("mbox irq clear", 1'b0, lirq)
        host(1'b1, 4'ha, 32'h0000_0008);
        host(1'b1, 4'h0, 32'h3);
        `CHK("one enable", 1'b0, lirq)
    endtask
    task automatic t_retry();
        @(posedge clk);
        go <= 1'b1;
        gwr <= 1'b1;
        gadr <= 4'h8;
        gwd <= 32'h0;
        host(1'b1, 4'h8, 32'h0000_0001);
        `CHK("retry", 2'b01, {ak, rt})
        `CHK("retry no write", 1'b0, lirq)
        host(1'b1, 4'hf, 32'hffff_ffff);
        host(1'b0, 4'hf, 32'h0);
        `CHK("unmapped", {1'b1, 32'h0}, {ak, rd})
        @(posedge clk);
        go <= 1'b1;
        gwr <= 1'b0;
        gadr <= 4'ha;
        host(1'b0, 4'h0, 32'h0);
        `CHK("retry ctl clash", {2'b01, 32'h0}, {ak, rt, rd})
        @(posedge clk);
        `CHK("local ctl read", 32'h0000_0008, mrd)
        @(posedge clk);
        go <= 1'b1;
        gadr <= 4'h1;
        host(1'b0, 4'h1, 32'h0);
        `CHK("mailbox no clash", {2'b10, ~32'h0a5a_0001}, {ak, rt, rd})
    endtask
    task automatic final_report();
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("irqs after reset", 2'b00, {pirq, lirq})
        t_bells();
        t_mbox();
        t_retry();
        final_report();
    end
endmodule
`default_nettype wire
